//--- design/port_detect_pkg.sv
// Shared constants and types for the graphics port mode detect block.
// Assumes one 50 MHz clock and a synchronous active-low reset.
package port_detect_pkg;

  // Clock rate, for reference by timing users
  localparam int unsigned CLK_MHZ = 50;

  // Reference level threshold in millivolts (0.55 V)
  localparam int unsigned REF_W = 10;
  localparam logic [REF_W-1:0] THRESH_MV = 10'h226;

  // Register offsets on the plain register port
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RATE = 8'h04;

  // Status register field positions
  localparam int unsigned ST_VALID = 0;
  localparam int unsigned ST_PORT_SEL = 1;
  localparam int unsigned ST_MODE_DET = 3;
  localparam int unsigned ST_LIVE = 4;
  localparam int unsigned ST_RATE_ERR = 5;
  localparam int unsigned ST_CMD_ERR = 6;
  localparam int unsigned ST_RATE_LSB = 8;
  localparam int unsigned ST_LOCK = 10;

  // Rate register field positions
  localparam int unsigned RT_RATE_LSB = 0;

  // Control signal positions on the nine-wire control vectors
  localparam int unsigned CTL_REQUEST = 0;
  localparam int unsigned CTL_GRANT = 1;
  localparam int unsigned CTL_DEVICE_SELECT = 2;
  localparam int unsigned CTL_FRAME = 3;
  localparam int unsigned CTL_INITIATOR_READY = 4;
  localparam int unsigned CTL_TARGET_READY = 5;
  localparam int unsigned CTL_STOP = 6;
  localparam int unsigned CTL_READ_FULL = 7;
  localparam int unsigned CTL_WRITE_FULL = 8;
  localparam int unsigned N_CTL = 9;

  // Sideband idle codes
  localparam logic [2:0] SBA_IDLE_LEGACY = 3'h7;
  localparam logic [2:0] SBA_IDLE_NEWER = 3'h0;

  typedef enum logic [1:0] {RATE_1X, RATE_2X, RATE_4X, RATE_8X} rate_t;

  // Rate in force until software chooses; legal in both modes
  localparam rate_t RATE_RST = RATE_4X;

  typedef struct packed {
    logic valid;
    logic port_sel;
    logic mode_det;
  } strap_t;

  typedef struct packed {
    logic mode_newer;
    logic ctrl_active_high;
    logic sba_inverted;
    logic [2:0] sba_idle_code;
    logic cmd_inverted;
    logic strobe_first_second;
    logic dbi_tx;
    logic dbi_rx;
    logic calib;
    logic pipe_allowed;
    logic newer_cmds;
    rate_t rate;
  } conv_t;

endpackage

//--- design/strap_capture.sv
// Captures the two strap bits once, at the first rising edge of power good.
// Assumes power good and the pin level are synchronous to sys_clk.
module strap_capture
  import port_detect_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic power_good,
  input wire logic detect_live,
  input wire logic parity_display_detect_pin,
  output strap_t straps
);

  logic pg_q, pg_d;
  strap_t strap_q, strap_d;

  always_comb begin
    pg_d = power_good;
    strap_d = strap_q;
    if (power_good && !pg_q && !strap_q.valid) begin
      strap_d.valid = 1'b1;
      strap_d.mode_det = detect_live;
      strap_d.port_sel = parity_display_detect_pin | detect_live;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pg_q <= 1'b0;
      strap_q <= '0;
    end else begin
      pg_q <= pg_d;
      strap_q <= strap_d;
    end
  end

  assign straps = strap_q;

endmodule

//--- design/graphics_port_mode_detect.sv
// What this block does
// - newer mode offers 8X and 4X fallback
// - newer 4X keeps all newer protocol features except transmit bus inversion
// - two-times rate never implemented
// - control signals low legacy, high newer
// - sideband normal 111 legacy, inverted 000
// - detect asserted when reference below 0.55 V
// - live detect chooses pull-up or termination
// - power good latches pin into port select
// - power good latches detect into status
// - detect bit ignored when video selected
// - legacy card latches graphics, legacy mode
// - detect one forces graphics port select
// - mode fixed once latched at power good, until reset
//
// Top of the graphics port mode detect block: reference comparator,
// strap capture, per-mode signaling conventions and a small register
// port. Inputs are synchronous to sys_clk; the reference level arrives
// as a millivolt code from an external converter.
//
// Added by the designer: the strobed register port and the address map.
module graphics_port_mode_detect
  import port_detect_pkg::*;
#(
  parameter int unsigned SBA_W = 8
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic power_good,
  input wire logic [REF_W-1:0] sensed_reference_input,
  input wire logic parity_display_detect_pin,
  output logic parity_pull_up_en,
  output logic parity_term_low_en,
  output logic graphics_not_video_select,
  output conv_t conv,
  input wire logic [N_CTL-1:0] ctrl_pin_in,
  output logic [N_CTL-1:0] ctrl_active,
  input wire logic [N_CTL-1:0] ctrl_active_in,
  output logic [N_CTL-1:0] ctrl_pin_out,
  input wire logic [SBA_W-1:0] sba_pin_in,
  output logic [SBA_W-1:0] sba_value,
  output logic sba_idle,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  output logic cmd_ok,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  function automatic logic rate_legal(rate_t r, logic newer);
    if (newer) begin
      rate_legal = (r == RATE_4X) || (r == RATE_8X);
    end else begin
      rate_legal = (r == RATE_1X) || (r == RATE_4X);
    end
  endfunction

  function automatic logic cmd_legal(logic [3:0] c, logic newer);
    unique case (c)
      4'h0, 4'h4, 4'ha, 4'hc: cmd_legal = 1'b1;
      4'h1, 4'h5, 4'h8, 4'h9: cmd_legal = !newer;
      default: cmd_legal = 1'b0;
    endcase
  endfunction

  strap_t straps;
  logic live_q, live_d;
  rate_t rate_q, rate_d;
  logic lock_q, lock_d;
  logic rate_err_q, rate_err_d;
  logic cmd_err_q, cmd_err_d;
  logic cmd_ok_q, cmd_ok_d;
  logic [31:0] rdata_q, rdata_d;
  conv_t conv_q, conv_d;
  logic [N_CTL-1:0] act_q, act_d, pin_q, pin_d;
  logic [SBA_W-1:0] sba_q, sba_d;
  logic idle_q, idle_d;
  logic newer;
  logic rate_wr, stat_wr;
  rate_t wr_rate;

  assign live_d = sensed_reference_input < THRESH_MV;

  strap_capture u_strap (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .power_good(power_good),
    .detect_live(live_q),
    .parity_display_detect_pin(parity_display_detect_pin),
    .straps(straps)
  );

  // detect counts only with the graphics port selected
  assign newer = straps.valid & straps.port_sel & straps.mode_det;

  // Signaling conventions
  always_comb begin
    conv_d = '0;
    conv_d.rate = rate_q;
    conv_d.mode_newer = newer;
    conv_d.ctrl_active_high = newer;
    conv_d.sba_inverted = newer;
    conv_d.sba_idle_code = newer ? SBA_IDLE_NEWER : SBA_IDLE_LEGACY;
    // pipe only legacy; newer strobes and command polarity
    conv_d.pipe_allowed = !newer;
    conv_d.cmd_inverted = newer;
    conv_d.strobe_first_second = newer;
    // transmit inversion only at newer 8X; newer 4X keeps the rest
    conv_d.dbi_tx = newer && (rate_q == RATE_8X);
    conv_d.dbi_rx = newer;
    conv_d.calib = newer;
    conv_d.newer_cmds = newer;
  end

  assign act_d = ctrl_pin_in ^ {N_CTL{~conv_q.ctrl_active_high}};
  assign pin_d = ctrl_active_in ^ {N_CTL{~conv_q.ctrl_active_high}};
  assign sba_d = sba_pin_in ^ {SBA_W{conv_q.sba_inverted}};
  assign idle_d = conv_q.sba_inverted ? (sba_pin_in == '0)
                                      : (sba_pin_in == '1);

  // Register port and rate control
  assign rate_wr = reg_wr && (reg_addr == OFS_RATE);
  assign stat_wr = reg_wr && (reg_addr == OFS_STATUS);
  assign wr_rate = rate_t'(reg_wdata[RT_RATE_LSB +: 2]);

  always_comb begin
    rate_d = rate_q;
    lock_d = lock_q;
    rate_err_d = rate_err_q & ~(stat_wr & reg_wdata[ST_RATE_ERR]);
    cmd_err_d = cmd_err_q & ~(stat_wr & reg_wdata[ST_CMD_ERR]);
    cmd_ok_d = 1'b0;
    if (rate_wr) begin
      // software picks a legal rate once: 8X or 4X newer, 1X or 4X legacy
      if (straps.valid && !lock_q && rate_legal(wr_rate, newer)) begin
        rate_d = wr_rate;
        lock_d = 1'b1;
      end else begin
        rate_err_d = 1'b1;
      end
    end
    if (cmd_valid) begin
      cmd_ok_d = straps.valid && cmd_legal(cmd_code, newer);
      if (!cmd_ok_d) begin
        cmd_err_d = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_STATUS: begin
          rdata_d[ST_VALID] = straps.valid;
          rdata_d[ST_PORT_SEL] = straps.port_sel;
          rdata_d[ST_MODE_DET] = straps.mode_det;
          rdata_d[ST_LIVE] = live_q;
          rdata_d[ST_RATE_ERR] = rate_err_q;
          rdata_d[ST_CMD_ERR] = cmd_err_q;
          rdata_d[ST_RATE_LSB +: 2] = rate_q;
          rdata_d[ST_LOCK] = lock_q;
        end
        OFS_RATE: rdata_d[RT_RATE_LSB +: 2] = rate_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      live_q <= 1'b0;
      rate_q <= RATE_RST;
      lock_q <= 1'b0;
      rate_err_q <= 1'b0;
      cmd_err_q <= 1'b0;
      cmd_ok_q <= 1'b0;
      rdata_q <= 32'h0;
      conv_q <= '0;
      act_q <= '0;
      pin_q <= '1;
      sba_q <= '0;
      idle_q <= 1'b0;
    end else begin
      live_q <= live_d;
      rate_q <= rate_d;
      lock_q <= lock_d;
      rate_err_q <= rate_err_d;
      cmd_err_q <= cmd_err_d;
      cmd_ok_q <= cmd_ok_d;
      rdata_q <= rdata_d;
      conv_q <= conv_d;
      act_q <= act_d;
      pin_q <= pin_d;
      sba_q <= sba_d;
      idle_q <= idle_d;
    end
  end

  assign parity_pull_up_en = ~live_q;
  assign parity_term_low_en = live_q;
  // legacy card leaves graphics selected with legacy mode
  assign graphics_not_video_select = straps.valid ? straps.port_sel : 1'b1;
  assign conv = conv_q;
  assign ctrl_active = act_q;
  assign ctrl_pin_out = pin_q;
  assign sba_value = sba_q;
  assign sba_idle = idle_q;
  assign cmd_ok = cmd_ok_q;
  assign reg_rdata = rdata_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence pg_first_rise;
    power_good && !$past(power_good) && !straps.valid;
  endsequence

  sequence rate_write_2x;
    rate_wr && (wr_rate == RATE_2X);
  endsequence

  AST_DETECT_LIVE: assert property (
    rst_b |=> live_q == $past(sensed_reference_input < THRESH_MV))
    else $error("live detect does not follow reference");

  AST_PULL_SELECT: assert property (
    rst_b |=> parity_term_low_en ==
      $past(sensed_reference_input < THRESH_MV) &&
      parity_pull_up_en == !parity_term_low_en)
    else $error("pull control does not follow detect");

  AST_STRAP_LATCH: assert property (
    pg_first_rise |=> straps.valid &&
      straps.port_sel == ($past(parity_display_detect_pin) | $past(live_q)))
    else $error("port select strap not latched");

  AST_MODE_LATCH: assert property (
    pg_first_rise |=> straps.mode_det == $past(live_q))
    else $error("mode detect strap not latched");

  AST_FORCE_GRAPHICS: assert property (
    straps.valid && straps.mode_det |-> straps.port_sel)
    else $error("detect did not force graphics select");

  AST_VIDEO_IGNORES: assert property (
    straps.valid && !straps.port_sel |=> ##1 !conv.mode_newer)
    else $error("video select took newer mode");

  AST_STRAPS_FIXED: assert property (
    straps.valid |=> $stable(straps))
    else $error("straps changed after capture");

  AST_CTRL_POLARITY: assert property (
    rst_b |=> ctrl_active == ($past(ctrl_pin_in) ^
      {N_CTL{~$past(conv.ctrl_active_high)}}))
    else $error("control polarity wrong");

  AST_PIN_POLARITY: assert property (
    rst_b |=> ctrl_pin_out == ($past(ctrl_active_in) ^
      {N_CTL{~$past(conv.ctrl_active_high)}}))
    else $error("control pin drive polarity wrong");

  AST_SBA_VALUE: assert property (
    rst_b |=> sba_value == ($past(sba_pin_in) ^
      {SBA_W{$past(conv.sba_inverted)}}))
    else $error("sideband value not normalised");

  // Conventions settle one cycle after reset ends
  AST_SBA_IDLE: assert property (
    rst_b && $past(rst_b) |-> conv.sba_idle_code ==
      (conv.mode_newer ? SBA_IDLE_NEWER : SBA_IDLE_LEGACY))
    else $error("sideband idle code wrong");

  AST_NO_2X: assert property (
    rate_write_2x |=> rate_err_q && rate_q != RATE_2X)
    else $error("two-times rate accepted");

  AST_DBI_4X: assert property (
    conv.mode_newer && conv.rate == RATE_4X |-> !conv.dbi_tx &&
      conv.calib)
    else $error("bus inversion on at newer 4X");

  AST_NEWER_FEATURES: assert property (
    conv.mode_newer |-> !conv.pipe_allowed && conv.strobe_first_second
      && conv.newer_cmds)
    else $error("newer mode lost a protocol feature");

  AST_CMD_SET: assert property (
    cmd_valid && cmd_code == 4'h1 && newer |=> !cmd_ok && cmd_err_q)
    else $error("legacy command accepted in newer mode");

  AST_RATE_SET: assert property (
    rate_wr && straps.valid && !lock_q && newer && wr_rate == RATE_8X
      |=> rate_q == RATE_8X ##2 conv.dbi_tx)
    else $error("eight-times rate not taken");

endmodule

//--- testbench/card_model.sv
// Add-in card on the graphics port: display, legacy or newer signaling.
// Assumes the board turns the card's detect pin into a reference level.
module card_model
  import port_detect_pkg::*;
(
  input wire logic [1:0] kind,
  input wire logic parity_pull_up_en,
  output logic [REF_W-1:0] ref_mv,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign ref_mv = (kind == 2'h2) ? 10'h15e : 10'h2ee;
  // only a floating pin follows the pull-up
  assign pin = (kind == 2'h1) ? parity_pull_up_en : 1'b0;
endmodule

//--- testbench/test_graphics_port_mode_detect.sv
// Self-checking bench: each card kind in turn, then conventions and port.
// Assumes the detect block top and the card model compiled before it.
module test_graphics_port_mode_detect
  import port_detect_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_b, power_good, pin, pu, tl, gnv, sba_idle;
  logic reg_wr, reg_rd, cmd_valid, cmd_ok, rd_p, cv_p, mode, psel;
  logic [1:0] kind, nr;
  logic [REF_W-1:0] ref_mv;
  conv_t conv;
  logic [N_CTL-1:0] cpi, ca, cai, cpo;
  logic [7:0] sbi, sbv, reg_addr;
  logic [3:0] cmd_code;
  logic [15:0] lm;
  logic [31:0] wd, rdata, r;
  logic [31:0] rq[$], cq[$];
  int num_errors, n_compared, seed;

  card_model CARD (.kind(kind), .parity_pull_up_en(pu), .ref_mv(ref_mv),
    .pin(pin));
  graphics_port_mode_detect DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .power_good(power_good), .sensed_reference_input(ref_mv),
    .parity_display_detect_pin(pin), .parity_pull_up_en(pu),
    .parity_term_low_en(tl), .graphics_not_video_select(gnv), .conv(conv),
    .ctrl_pin_in(cpi), .ctrl_active(ca), .ctrl_active_in(cai),
    .ctrl_pin_out(cpo), .sba_pin_in(sbi), .sba_value(sbv),
    .sba_idle(sba_idle), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_ok(cmd_ok), .reg_addr(reg_addr), .reg_wdata(wd), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata));

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    wd <= d;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp);
    rq.push_back(exp);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
  endtask

  // Strobes drop only after a burst, so none is set twice in one step
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  function automatic logic [31:0] st(logic e5, logic e6, logic [1:0] rt,
    logic lk);
    st = 32'h1;
    st[1] = psel;
    st[3] = mode;
    st[4] = mode;
    st[5] = e5;
    st[6] = e6;
    st[9:8] = rt;
    st[10] = lk;
  endfunction

  // Read data and command results checked the cycle after their strobe
  always @(posedge sys_clk) begin
    if (rd_p) check("rdata", rdata, rq.pop_front());
    if (cv_p) check("cmd_ok", {31'h0, cmd_ok}, cq.pop_front());
    rd_p <= reg_rd;
    cv_p <= cmd_valid;
  end

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    num_errors++;
    conclude();
  end

  initial begin
    {rst_b, power_good, reg_wr, reg_rd, cmd_valid} = '0;
    {kind, cpi, cai, sbi, reg_addr, cmd_code, wd} = '0;
    seed = 32'hedf5;
    for (int k = 0; k < 3; k++) begin
      kind <= k[1:0];
      rst_b <= 1'b0;
      power_good <= 1'b0;
      cyc(6);
      rst_b <= 1'b1;
      cyc(3);
      mode = (k == 2);
      psel = (k != 0);
      check("pull_up", {31'h0, pu}, {31'h0, !mode});
      check("term_low", {31'h0, tl}, {31'h0, mode});
      power_good <= 1'b1;
      cyc(3);
      check("select", {31'h0, gnv}, {31'h0, psel});
      check("newer", {31'h0, conv.mode_newer}, {31'h0, mode});
      rd(OFS_STATUS, st(1'b0, 1'b0, 2'h2, 1'b0));
      idle();
      check("act_high", {31'h0, conv.ctrl_active_high}, {31'h0, mode});
      check("sba_inv", {31'h0, conv.sba_inverted}, {31'h0, mode});
      check("sba_code", {29'h0, conv.sba_idle_code},
        mode ? 32'h0 : 32'h7);
      check("calib", {31'h0, conv.calib}, {31'h0, mode});
      check("dbi_rx", {31'h0, conv.dbi_rx}, {31'h0, mode});
      check("dbi_tx4", {31'h0, conv.dbi_tx}, 32'h0);
      check("pipe", {31'h0, conv.pipe_allowed}, {31'h0, !mode});
      check("cmd_inv", {31'h0, conv.cmd_inverted}, {31'h0, mode});
      check("strobe", {31'h0, conv.strobe_first_second},
        {31'h0, mode});
      check("cmd_set", {31'h0, conv.newer_cmds}, {31'h0, mode});
      check("rate4", {30'h0, conv.rate}, 32'h2);
      repeat (8) begin
        r = $random(seed);
        cai <= r[8:0];
        cpi <= r[17:9];
        sbi <= r[31] ? {8{~mode}} : r[25:18];
        cyc(2);
        check("pin_out", {23'h0, cpo}, {23'h0, mode ? cai : ~cai});
        check("active", {23'h0, ca}, {23'h0, mode ? cpi : ~cpi});
        check("sba_val", {24'h0, sbv}, {24'h0, sbi ^ {8{mode}}});
        check("sba_idle", {31'h0, sba_idle},
          {31'h0, sbi == {8{~mode}}});
      end
      lm = mode ? 16'h1411 : 16'h1733;
      for (int c = 0; c < 16; c++) begin
        cq.push_back({31'h0, lm[c]});
        cmd_code <= c[3:0];
        cmd_valid <= 1'b1;
        @(posedge sys_clk);
      end
      cmd_valid <= 1'b0;
      nr = mode ? 2'h3 : 2'h0;
      wr(OFS_RATE, 32'h1);
      wr(OFS_RATE, {30'h0, ~nr});
      rd(OFS_STATUS, st(1'b1, 1'b1, 2'h2, 1'b0));
      wr(OFS_RATE, {30'h0, nr});
      idle();
      cyc(2);
      check("rate", {30'h0, conv.rate}, {30'h0, nr});
      check("dbi_tx", {31'h0, conv.dbi_tx}, {31'h0, mode});
      wr(OFS_RATE, 32'h2);
      wr(OFS_STATUS, 32'h60);
      rd(OFS_STATUS, st(1'b0, 1'b0, nr, 1'b1));
      wr(8'h10, 32'hffffffff);
      rd(8'h10, 32'h0);
      rd(OFS_STATUS, st(1'b0, 1'b0, nr, 1'b1));
      idle();
      power_good <= 1'b0;
      kind <= 2'((k + 1) % 3);
      cyc(2);
      power_good <= 1'b1;
      cyc(3);
      check("keep_sel", {31'h0, gnv}, {31'h0, psel});
      check("keep_mode", {31'h0, conv.mode_newer}, {31'h0, mode});
      $display("test card kind %0d done", k);
    end
    cyc(2);
    conclude();
  end
endmodule
